// ### strap_pkg.sv
/*
 * shared constants and types for the reset, strap and host port block.
 * assumes a single 125 MHz clock and pins already synchronous to it.
 */
package strap_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 125000;              // clock rate in kHz
    localparam int READY_WAIT_MS = 125;           // wait before host access
    localparam int READY_CYCLES = READY_WAIT_MS * CLK_KHZ;
    localparam int READY_CNT_W = 24;              // holds READY_CYCLES

    // ------------------------------------------------------------
    // strap pin positions on the gpio bus
    // ------------------------------------------------------------
    localparam int GPIO_N = 7;                    // gpio0..gpio6
    localparam int STRAP_RATE_LO = 0;             // master clock rate bit 0
    localparam int STRAP_RATE_HI = 1;             // master clock rate bit 1
    localparam int STRAP_PROTO = 3;               // host_protocol_strap
    localparam int STRAP_LOW = 4;                 // must_be_low_strap

    // ------------------------------------------------------------
    // serial host port framing
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;               // command, address, data
    localparam int CMD_BITS = 8;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 8;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ = 8'h03;

    // ------------------------------------------------------------
    // register addresses and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;   // ready flag lives here
    localparam int READY_BIT = 7;
    localparam logic [7:0] ADDR_GPIO_CFG = 8'h01; // 0x01..0x07, one per pin
    localparam logic [7:0] ADDR_CTRL = 8'h08;     // output enable bits
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] GPIO_CFG_RESET = 3'h0;

    // gpio pin functions
    typedef enum logic [2:0] {
        FN_INPUT,
        FN_LOCK,
        FN_REF_FAIL,
        FN_REF_SEL,
        FN_OUT_EN,
        FN_HOST_IRQ
    } gpio_fn_t;

    // straps caught when reset is released
    typedef struct packed {
        logic host_i2c;          // 1: i2c host port, 0: spi
        logic must_low_bad;      // must_be_low_strap was seen high
        logic [1:0] clk_rate;    // master clock rate selection
    } strap_t;

endpackage

// ### reg_mem.sv
/*
 * small register storage with one write port and a registered read port.
 * assumes the caller holds the address stable in the read cycle.
 */
module reg_mem
    import strap_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];   // contents are undefined until written

    // ------------------------------------------------------------
    // write port
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // ------------------------------------------------------------
    // read port, data held in a register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata <= '0;
        end
        else if (re)
        begin
            rdata <= mem[raddr];
        end
    end

endmodule

// ### reset_strap_host_port.sv
/*
 * reset sequencing, strap capture, gpio function routing and the spi host port.
 * assumes reset_n is the power-on reset pin and every pin is synchronous to clk;
 * spi clock halves must each last at least two clk periods.
 */
// What this block does
// - low reset input clears all logic but the register memory
// - access allowed after 125 ms ready flag
// - straps on gpio 0,1,3,4 after reset
// - gpio 1,0 pick master clock rate
// - gpio 5 and 6 ignored as straps
// - each gpio takes a selectable function
// - spi input carries command, address, data
// - spi read data leaves on serial output
// - i2c mode: clock and data lines, data line never driven
// - i2c mode: serial output pin picks address
// - chip select frames spi, else address
module reset_strap_host_port
    import strap_pkg::*;
#(
    parameter int READY_WAIT = READY_CYCLES
)
(
    // clock and power-on reset
    input wire logic clk,
    input wire logic reset_n,
    // gpio pins
    input wire logic [GPIO_N-1:0] gpio_in,
    output logic [GPIO_N-1:0] gpio_out,
    output logic [GPIO_N-1:0] gpio_oe,
    // host port pins
    input wire logic sck_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic serial_out_addr_sel_pin_in,
    output logic serial_out_addr_sel_pin_out,
    output logic serial_out_addr_sel_pin_oe,
    input wire logic select_n_addr_sel_pin,
    // device status feeding gpio functions
    input wire logic dpll_lock,
    input wire logic ref_fail,
    // configuration and status
    output logic ready,
    output strap_t straps,
    output logic [1:0] i2c_addr_sel,
    output logic ref_sel_req
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [READY_CNT_W-1:0] wait_cnt_reg;          // counts toward ready
    logic caught_reg;                              // straps taken once
    logic sck_prev_reg;                            // for edge detection
    logic [4:0] bit_cnt_reg;                       // bits of the frame so far
    logic [FRAME_BITS-1:0] shift_in_reg;           // command, address, data
    logic [DATA_BITS-1:0] shift_out_reg;           // read data going out
    logic rd_pend_reg;                             // memory read under way
    logic rd_status_reg;                           // that read targets status
    logic rd_ctrl_reg; // that read targets the control bits
    logic irq_reg;                                 // host interrupt flag
    logic lock_prev_reg;
    logic fail_prev_reg;
    logic [7:0] ctrl_reg;                          // output enable bits
    logic [2:0] gpio_cfg_reg [GPIO_N];             // function per pin
    logic [DATA_BITS-1:0] mem_rdata;
    logic spi_on;
    logic sck_rise;
    logic sck_fall;
    logic [4:0] bit_cnt_next;
    logic [FRAME_BITS-1:0] shift_in_next;
    logic wr_done;
    logic rd_start;
    logic [ADDR_BITS-1:0] wr_addr;
    logic [DATA_BITS-1:0] wr_data;
    logic [GPIO_N-1:0] ref_sel_hits;

    // ------------------------------------------------------------
    // ready timer: host access waits for this
    // ------------------------------------------------------------
    // the async reset clears the timer so each power-on restarts it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_cnt_reg <= '0;
            ready <= 1'b0;
        end
        else if (!ready)
        begin
            if (wait_cnt_reg == READY_CNT_W'(READY_WAIT - 1))
            begin
                ready <= 1'b1;
            end
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // strap capture on the first edge after reset release
    // ------------------------------------------------------------
    // gpio5 and gpio6 are not looked at here at all
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            caught_reg <= 1'b0;
            straps <= '0;
            i2c_addr_sel <= 2'h0;
        end
        else if (!caught_reg)
        begin
            caught_reg <= 1'b1;
            straps.host_i2c <= gpio_in[STRAP_PROTO];
            straps.must_low_bad <= gpio_in[STRAP_LOW];
            straps.clk_rate <= {gpio_in[STRAP_RATE_HI], gpio_in[STRAP_RATE_LO]};
            // address select pins only matter in i2c mode
            i2c_addr_sel <= {serial_out_addr_sel_pin_in, select_n_addr_sel_pin};
        end
    end

    // ------------------------------------------------------------
    // spi receive framing
    // ------------------------------------------------------------
    assign spi_on = ready && caught_reg && !straps.host_i2c;
    assign sck_rise = sck_in && !sck_prev_reg;
    assign sck_fall = !sck_in && sck_prev_reg;
    assign shift_in_next = {shift_in_reg[FRAME_BITS-2:0], sda_in};
    assign bit_cnt_next = bit_cnt_reg + 1'b1;
    // taken from the next value: on the last rise the address sits one bit higher
    assign wr_addr = shift_in_next[DATA_BITS +: ADDR_BITS];
    assign wr_data = shift_in_next[DATA_BITS-1:0];
    // last data bit of a write frame completes the write
    assign wr_done = spi_on && !select_n_addr_sel_pin && sck_rise
        && bit_cnt_next == 5'(FRAME_BITS) && shift_in_reg[FRAME_BITS-2 -: CMD_BITS] == CMD_WRITE;
    // last address bit of a read frame starts the memory read
    assign rd_start = spi_on && !select_n_addr_sel_pin && sck_rise
        && bit_cnt_next == 5'(CMD_BITS + ADDR_BITS) && shift_in_reg[ADDR_BITS+CMD_BITS-2 -: CMD_BITS] == CMD_READ;

    // chip select low frames every transfer; high restarts the count
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sck_prev_reg <= 1'b0;
            bit_cnt_reg <= '0;
            shift_in_reg <= '0;
        end
        else
        begin
            sck_prev_reg <= sck_in;
            if (!spi_on || select_n_addr_sel_pin)
            begin
                bit_cnt_reg <= '0;
            end
            else if (sck_rise && bit_cnt_reg != 5'(FRAME_BITS))
            begin
                bit_cnt_reg <= bit_cnt_next;
                shift_in_reg <= shift_in_next;
            end
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    reg_mem #(
        .AW(ADDR_BITS),
        .DW(DATA_BITS)
    ) u_mem (
        .clk(clk),
        .reset_n(reset_n),
        .we(wr_done),
        .waddr(wr_addr),
        .wdata(wr_data),
        .re(rd_start),
        .raddr(shift_in_next[ADDR_BITS-1:0]),
        .rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // shadow copies of registers that steer logic
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < GPIO_N; i++)
        begin : g_cfg
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    gpio_cfg_reg[i] <= GPIO_CFG_RESET;
                end
                else if (wr_done && wr_addr == ADDR_GPIO_CFG + 8'(i))
                begin
                    gpio_cfg_reg[i] <= wr_data[2:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= CTRL_RESET;
        end
        else if (wr_done && wr_addr == ADDR_CTRL)
        begin
            ctrl_reg <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // host interrupt: set on a lock or fail change, write status to clear
    // ------------------------------------------------------------
    // a change in the clearing cycle keeps the flag set
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_prev_reg <= 1'b0;
            fail_prev_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            lock_prev_reg <= dpll_lock;
            fail_prev_reg <= ref_fail;
            if (ready && (dpll_lock != lock_prev_reg || ref_fail != fail_prev_reg))
            begin
                irq_reg <= 1'b1;
            end
            else if (wr_done && wr_addr == ADDR_STATUS)
            begin
                irq_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // spi read data out on the serial output pin
    // ------------------------------------------------------------
    // the pin only drives during a read frame in spi mode; in i2c mode it
    // stays an input so the address select level is never fought
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_pend_reg <= 1'b0;
            rd_status_reg <= 1'b0;
            rd_ctrl_reg <= 1'b0;
            shift_out_reg <= '0;
            serial_out_addr_sel_pin_out <= 1'b0;
            serial_out_addr_sel_pin_oe <= 1'b0;
        end
        else
        begin
            rd_pend_reg <= rd_start;
            if (rd_start)
            begin
                rd_status_reg <= shift_in_next[ADDR_BITS-1:0] == ADDR_STATUS;
                // control bits read back from their register, which has a reset value
                rd_ctrl_reg <= shift_in_next[ADDR_BITS-1:0] == ADDR_CTRL;
            end
            if (!spi_on || select_n_addr_sel_pin)
            begin
                serial_out_addr_sel_pin_oe <= 1'b0;
            end
            else if (rd_pend_reg)
            begin
                // status: ready, interrupt, bad strap, protocol, clock rate
                shift_out_reg <= rd_status_reg
                    ? {ready, 2'h0, irq_reg, straps.must_low_bad, straps.host_i2c, straps.clk_rate}
                    : rd_ctrl_reg ? ctrl_reg : mem_rdata;
                serial_out_addr_sel_pin_out <= rd_status_reg ? ready
                    : rd_ctrl_reg ? ctrl_reg[DATA_BITS-1] : mem_rdata[DATA_BITS-1];
                serial_out_addr_sel_pin_oe <= 1'b1;
            end
            else if (sck_fall && serial_out_addr_sel_pin_oe)
            begin
                // the fall after the last address bit shows bit 7, so the host
                // takes it on the first data rise and no bit is lost
                serial_out_addr_sel_pin_out <= shift_out_reg[DATA_BITS-1];
                shift_out_reg <= {shift_out_reg[DATA_BITS-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // i2c data line: held released, the pin is left open
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // gpio function routing
    // ------------------------------------------------------------
    // pins stay released until ready so board strap drivers never clash
    generate
        for (genvar i = 0; i < GPIO_N; i++)
        begin : g_gpio
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    gpio_out[i] <= 1'b0;
                    gpio_oe[i] <= 1'b0;
                end
                else
                begin
                    gpio_oe[i] <= 1'b0;
                    gpio_out[i] <= 1'b0;
                    case (gpio_fn_t'(gpio_cfg_reg[i]))
                        FN_LOCK:
                        begin
                            gpio_out[i] <= dpll_lock;
                            gpio_oe[i] <= ready;
                        end
                        FN_REF_FAIL:
                        begin
                            gpio_out[i] <= ref_fail;
                            gpio_oe[i] <= ready;
                        end
                        FN_OUT_EN:
                        begin
                            gpio_out[i] <= ctrl_reg[i];
                            gpio_oe[i] <= ready;
                        end
                        FN_HOST_IRQ:
                        begin
                            gpio_out[i] <= irq_reg;
                            gpio_oe[i] <= ready;
                        end
                        default:
                        begin
                            gpio_out[i] <= 1'b0; // input or reference select monitor
                        end
                    endcase
                end
            end
            assign ref_sel_hits[i] = gpio_cfg_reg[i] == 3'(FN_REF_SEL) && gpio_in[i];
        end
    endgenerate

    // reference select request taken from any pin set to that function
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ref_sel_req <= 1'b0;
        end
        else
        begin
            ref_sel_req <= ready && |ref_sel_hits;
        end
    end

endmodule

// ### reset_strap_host_port_checker.sv
/*
 * concurrent checks on the reset, strap and host port block.
 * assumes it is bound to reset_strap_host_port and sees only its ports.
 */
module reset_strap_host_port_checker
    import strap_pkg::*;
#(
    parameter int READY_WAIT = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // gpio pins
    input wire logic [GPIO_N-1:0] gpio_in,
    input wire logic [GPIO_N-1:0] gpio_oe,
    // host port pins
    input wire logic sda_oe,
    input wire logic serial_out_addr_sel_pin_in,
    input wire logic serial_out_addr_sel_pin_oe,
    input wire logic select_n_addr_sel_pin,
    // status
    input wire logic ready,
    input wire strap_t straps,
    input wire logic [1:0] i2c_addr_sel,
    input wire logic ref_sel_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // cycles since release; saturates so it never wraps in long runs
    int rel_cnt_reg;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rel_cnt_reg <= 0;
        else if (rel_cnt_reg < READY_WAIT)
            rel_cnt_reg <= rel_cnt_reg + 1;
    end

    default clocking cb @(posedge clk); endclocking

    // first edge that sees reset released
    sequence released_s;
        $rose(reset_n);
    endsequence
    // chip select seen high on two edges in a row
    sequence deselected_s;
        select_n_addr_sel_pin ##1 select_n_addr_sel_pin;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    reset_clear_a: assert property (!reset_n |-> !ready && gpio_oe == 7'h00 && straps == 4'h0)
        else $error("outputs not clear in reset");
    ready_time_a: assert property (disable iff (!reset_n) ready == (rel_cnt_reg >= READY_WAIT))
        else $error("ready flag at wrong cycle");
    ready_hold_a: assert property (disable iff (!reset_n) ready |=> ready)
        else $error("ready flag dropped");
    quiet_early_a: assert property (disable iff (!reset_n)
        !ready |-> gpio_oe == 7'h00 && !serial_out_addr_sel_pin_oe && !ref_sel_req)
        else $error("activity before ready");
    strap_take_a: assert property (disable iff (!reset_n) released_s |=>
        straps == {$past(gpio_in[STRAP_PROTO]), $past(gpio_in[STRAP_LOW]), $past(gpio_in[1:0])})
        else $error("straps not taken at release");
    addr_sel_take_a: assert property (disable iff (!reset_n) released_s |=>
        i2c_addr_sel == {$past(serial_out_addr_sel_pin_in), $past(select_n_addr_sel_pin)})
        else $error("address select not taken");
    straps_hold_a: assert property (disable iff (!reset_n)
        !$rose(reset_n) |=> $stable(straps) && $stable(i2c_addr_sel))
        else $error("straps moved after release");
    i2c_quiet_a: assert property (disable iff (!reset_n)
        straps.host_i2c |-> !sda_oe && !serial_out_addr_sel_pin_oe)
        else $error("spi output driven in i2c mode");
    spi_release_a: assert property (disable iff (!reset_n) deselected_s |-> !serial_out_addr_sel_pin_oe)
        else $error("serial out driven while deselected");
endmodule

bind reset_strap_host_port reset_strap_host_port_checker #(.READY_WAIT(READY_WAIT)) chk_u (
    .clk(clk), .reset_n(reset_n), .gpio_in(gpio_in), .gpio_oe(gpio_oe), .sda_oe(sda_oe),
    .serial_out_addr_sel_pin_in(serial_out_addr_sel_pin_in),
    .serial_out_addr_sel_pin_oe(serial_out_addr_sel_pin_oe),
    .select_n_addr_sel_pin(select_n_addr_sel_pin), .ready(ready), .straps(straps),
    .i2c_addr_sel(i2c_addr_sel), .ref_sel_req(ref_sel_req));

// ### spi_host_model.sv
/*
 * behavioural spi host (mode 0, msb first) facing the device port.
 * assumes miso is the resolved serial-out wire; clock stands low between frames.
 */
module spi_host_model
(
    // clock
    input wire logic clk,
    // pins toward the device
    output logic sck,
    output logic mosi,
    output logic select_n,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: deselected, clock low
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        select_n = 1'b1;
    end

    // one whole frame; half is clk cycles per sck half (>= 2 keeps the read bit settled)
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] wdata,
                        input int half, output logic [7:0] rdata);
        logic [23:0] frame;
        frame = {cmd, addr, wdata};
        rdata = 8'h00;
        @(posedge clk);
        select_n <= 1'b0;
        for (int b = 23; b >= 0; b--)
        begin
            mosi <= frame[b];
            repeat (half) @(posedge clk);
            // read bits are taken just before the rising edge
            if (b < 8)
                rdata[b] = miso;
            sck <= 1'b1;
            repeat (half) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (half) @(posedge clk);
        select_n <= 1'b1;
        // released line: show the inverse, never a stale bit
        mosi <= ~mosi;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ### tb_reset_strap_host_port.sv
/*
 * self-checking bench for the reset, strap and host port block.
 * assumes spi_host_model as host and a shortened ready wait.
 */
module tb_reset_strap_host_port;
    timeunit 1ns;
    timeprecision 1ps;
    import strap_pkg::*;

    localparam int RW = 400; // long enough for a whole frame before ready
    logic clk, reset_n, so_lvl, dpll_lock, ref_fail, sck, mosi, sel_n;
    logic [6:0] gpio_drv, gpio_out, gpio_oe;
    logic so_out, so_oe, sda_out, sda_oe, ready, ref_sel_req;
    logic [1:0] i2c_addr_sel;
    strap_t straps;
    int n_fail = 0, num_checks = 0, cyc = 0, rel_cyc = 0;
    // resolved wires: device drive wins while enabled
    wire logic [6:0] gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_drv);
    wire logic so_in = so_oe ? so_out : so_lvl;
    wire logic sda_in = sda_oe ? sda_out : mosi;

    reset_strap_host_port #(.READY_WAIT(RW)) dut_u (.clk(clk), .reset_n(reset_n), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .sck_in(sck), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .serial_out_addr_sel_pin_in(so_in), .serial_out_addr_sel_pin_out(so_out),
        .serial_out_addr_sel_pin_oe(so_oe), .select_n_addr_sel_pin(sel_n), .dpll_lock(dpll_lock),
        .ref_fail(ref_fail), .ready(ready), .straps(straps), .i2c_addr_sel(i2c_addr_sel),
        .ref_sel_req(ref_sel_req));
    spi_host_model host_u (.clk(clk), .sck(sck), .mosi(mosi), .select_n(sel_n), .miso(so_in));

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        host_u.xfer(CMD_WRITE, a, d, 5, r);
    endtask

    // straps driven by the board through reset and left driven after release
    task automatic do_reset(input logic [6:0] g, input logic so);
        reset_n <= 1'b0;
        gpio_drv <= g;
        so_lvl <= so;
        repeat (2) @(posedge clk);
        check("clear in reset", {ready, gpio_oe}, 16'h0000);
        reset_n <= 1'b1;
        rel_cyc = cyc + 1;
        repeat (2) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every rate and both protocols; gpio5/6 swing against the straps
    task automatic test_straps();
        logic [6:0] g;
        logic [7:0] r;
        for (int i = 0; i < 4; i++)
        begin
            g = {~i[1], ~i[0], i[0] & i[1], i[0] ^ i[1], i[0], i[1:0]};
            do_reset(g, i[1]);
            check("straps", straps, {g[3], g[4], g[1:0]});
            check("addr sel", i2c_addr_sel, {i[1], 1'b1});
            if (i == 0)
                wr(ADDR_CTRL, 8'hff); // refused: still initialising
            while (!ready && cyc < rel_cyc + 2000)
                @(posedge clk);
            check("ready wait", cyc - rel_cyc, RW);
            host_u.xfer(CMD_READ, ADDR_STATUS, 8'h00, 9, r);
            if (g[3])
                check("i2c silent", r, {8{i[1]}});
            else
                check("status", r, {4'h8, g[4], g[3], g[1:0]});
            if (i == 0)
            begin
                host_u.xfer(CMD_READ, ADDR_CTRL, 8'h00, 5, r);
                check("early write", r, CTRL_RESET);
            end
        end
        $display("test_straps done");
    endtask

    // gpio functions after the straps are released
    task automatic test_gpio_fn();
        logic [7:0] ad [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, ADDR_CTRL};
        logic [7:0] va [6] = '{8'h01, 8'h03, 8'h04, 8'h02, 8'h05, 8'h04};
        logic [7:0] r;
        gpio_drv <= 7'h00;
        for (int k = 0; k < 6; k++)
            wr(ad[k], va[k]);
        repeat (4) @(posedge clk);
        check("gpio oe", gpio_oe, 7'h2d);
        check("gpio out", gpio_out & 7'h0d, 7'h05);
        gpio_drv <= 7'h02;
        repeat (4) @(posedge clk);
        check("ref sel", ref_sel_req, 1'b1);
        ref_fail <= 1'b1;
        repeat (4) @(posedge clk);
        check("fail out", gpio_out[3], 1'b1);
        check("irq pin", gpio_out[5], 1'b1);
        host_u.xfer(CMD_READ, ADDR_STATUS, 8'h00, 5, r);
        check("irq set", r, 8'h9b);
        wr(ADDR_STATUS, 8'h00);
        host_u.xfer(CMD_READ, ADDR_STATUS, 8'h00, 5, r);
        check("irq clear", r, 8'h8b);
        check("irq pin clear", gpio_out[5], 1'b0);
        $display("test_gpio_fn done");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        // high first so the first do_reset gives a clean falling edge
        reset_n = 1'b1;
        gpio_drv = 7'h00;
        so_lvl = 1'b0;
        dpll_lock = 1'b1;
        ref_fail = 1'b0;
        test_straps();
        test_gpio_fn();
        finish_test();
    end

    // whole run needs about 5900 cycles
    initial
    begin
        repeat (30000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        finish_test();
    end
endmodule
